/* File: eac_ctrl.sv */
// EEPROM access control: register slave, serial engine, autoload sequencer
// Function
// [R1] A zero-to-one write of the request bit starts one EEPROM cycle.
// [R2] Hardware clears the request bit when the cycle finishes.
// [R3] Command bit zero reads, one writes; resets to zero.
// [R4] Missing EEPROM acknowledge sets the read-only error flag; resets to zero.
// [R5] Autoload-complete flag reads one only after a successful autoload.
// [R6] EEPROM clock is core clock divided by 4096, 2048, 1024 or 128.
// [R7] Autoload runs when the disable bit is zero, skipped when one; code always starts it at reset, a one ends it after the current word.
// [R8] Fast-autoload bit 7 makes autoload run 32 times faster.
// [R9] Bit 8 reads one while autoload is under way.
// [R10] Bits 15:9 give the word address of a software cycle.
// [R11] Bits 31:16 give the data written by a software write cycle.
// [R12] A finished software read places the returned word in bits 31:16.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module eac_ctrl (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt
    output logic             irq,
    // Serial EEPROM pins
    output logic             ee_scl,
    input  wire logic        ee_sda_in,
    output logic             ee_sda_out,
    output logic             ee_sda_oe,
    // Autoloaded words
    output logic             ld_valid,
    output logic [6:0]       ld_addr,
    output logic [15:0]      ld_data
);
    import eac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic        resp_reg, start_reg, cmd_reg, err_reg, al_done_reg, al_dis_reg;
    logic        fast_reg, al_busy_reg, arm_reg, op_rd_reg, op_sw_reg, fail_reg;
    logic        scl_reg, oe_reg, ld_valid_reg;
    logic [1:0]  freq_reg, q_reg, q_next;
    logic [2:0]  bit_reg, bit_next, idx_reg, idx_next, ist_reg, mask_reg, ev;
    logic [6:0]  waddr_reg, op_addr_reg, al_addr_reg;
    logic [7:0]  sh_reg, sh_next;
    logic [15:0] data_reg, rx_reg;
    logic [31:0] rd_reg, ctrl_word, rd_mux;
    eac_state_t  state_reg, state_next;

    logic req, acc, hit_ctrl, hit_stat, hit_mask, wr_ctrl, wr_mask, rd_stat;
    logic run, tick, step, sample, rx_phase, nack, fin, go_al, go_sw, go;
    logic al_end, sw_rd_ok, start_rise, scl_v, oe_v, div_fast;
    logic [2:0] last_idx;

    function automatic logic [7:0] tx_byte(input logic [2:0] idx, input logic rd,
                                           input logic [6:0] addr,
                                           input logic [15:0] data);
        tx_byte = SEL_WR;
        if (idx == 3'h1) begin
            tx_byte = {1'b0, addr};
        end else if (idx == 3'h2) begin
            tx_byte = rd ? SEL_RD : data[15:8];
        end else if (idx == 3'h3) begin
            tx_byte = data[7:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode; every access answers on the second cycle
    assign req             = avs_read || avs_write;
    assign acc             = req && resp_reg;
    assign avs_waitrequest = req && !resp_reg;
    assign hit_ctrl        = (avs_address == OFS_CTRL);
    assign hit_stat        = (avs_address == OFS_IRQ_STAT);
    assign hit_mask        = (avs_address == OFS_IRQ_MASK);
    assign wr_ctrl         = acc && avs_write && hit_ctrl;
    assign wr_mask         = acc && avs_write && hit_mask && avs_byteenable[0];
    assign rd_stat         = acc && avs_read && hit_stat;
    assign start_rise      = wr_ctrl && avs_byteenable[0] &&
                             avs_writedata[B_START] && !start_reg; // [R1]
    assign ctrl_word = {data_reg, waddr_reg, al_busy_reg, fast_reg, al_dis_reg,
                        freq_reg, al_done_reg, err_reg, cmd_reg, start_reg}; // [R9]
    assign rd_mux = hit_ctrl ? ctrl_word :
                    hit_stat ? {29'h0, ist_reg} :
                    hit_mask ? {29'h0, mask_reg} : 32'h0000_0000;
    assign avs_readdata = rd_reg;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            resp_reg <= 1'b0;
            rd_reg   <= 32'h0000_0000;
        end else begin
            resp_reg <= req && !resp_reg;
            rd_reg   <= (req && !resp_reg) ? rd_mux : rd_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine
    assign run      = (state_reg != EAC_IDLE);
    assign step     = tick && (q_reg == 2'h3);
    assign sample   = tick && (q_reg == 2'h2);
    assign last_idx = op_rd_reg ? 3'h4 : 3'h3;
    assign rx_phase = op_rd_reg && (idx_reg >= 3'h3);
    assign nack     = (state_reg == EAC_ACK) && sample && !rx_phase && ee_sda_in; // [R4]
    assign fin      = (state_reg == EAC_STOP) && step;
    assign go_al    = (state_reg == EAC_IDLE) && al_busy_reg;
    assign go_sw    = (state_reg == EAC_IDLE) && !al_busy_reg && start_reg; // [R1]
    assign go       = go_al || go_sw;
    assign div_fast = fast_reg && al_busy_reg; // [R8]

    eac_clkdiv u_div (
        .clk_sys (clk_sys),
        .srst    (srst),
        .run     (run),
        .sel     (freq_reg),
        .fast    (div_fast),
        .tick    (tick)
    );

    always_comb begin
        state_next = state_reg;
        q_next     = run ? q_reg + {1'b0, tick} : 2'h0;
        idx_next   = idx_reg;
        bit_next   = bit_reg;
        sh_next    = sh_reg;
        unique case (state_reg)
            EAC_IDLE: begin
                if (go) begin
                    state_next = EAC_START;
                    idx_next   = 3'h0;
                end
            end
            EAC_START: begin
                if (step) begin
                    state_next = EAC_BITS;
                    sh_next    = tx_byte(idx_reg, op_rd_reg, op_addr_reg, data_reg);
                    bit_next   = 3'h7;
                end
            end
            EAC_BITS: begin
                if (step) begin
                    state_next = (bit_reg == 3'h0) ? EAC_ACK : EAC_BITS;
                    bit_next   = bit_reg - 3'h1;
                    sh_next    = {sh_reg[6:0], 1'b0};
                end
            end
            EAC_ACK: begin
                // A missing acknowledge abandons the frame with a stop
                if (step) begin
                    if (fail_reg || idx_reg == last_idx) begin
                        state_next = EAC_STOP;
                    end else if (op_rd_reg && idx_reg == 3'h1) begin
                        state_next = EAC_START;
                        idx_next   = 3'h2;
                    end else begin
                        state_next = EAC_BITS;
                        idx_next   = idx_reg + 3'h1;
                        bit_next   = 3'h7;
                        sh_next    = tx_byte(idx_reg + 3'h1, op_rd_reg, op_addr_reg,
                                             data_reg); // [R10] [R11]
                    end
                end
            end
            EAC_STOP: begin
                if (step) begin
                    state_next = EAC_IDLE;
                end
            end
        endcase
    end

    // Pin levels; the low drive of the open-drain data line is the enable
    assign scl_v = (state_reg == EAC_IDLE) ? 1'b1 :
                   (state_reg == EAC_START || state_reg == EAC_STOP) ? (q_reg != 2'h0) :
                   (q_reg == 2'h1 || q_reg == 2'h2);
    assign oe_v  = (state_reg == EAC_START) ? (q_reg >= 2'h2) :
                   (state_reg == EAC_STOP)  ? (q_reg < 2'h2) :
                   (state_reg == EAC_BITS)  ? (!rx_phase && !sh_reg[7]) :
                   (state_reg == EAC_ACK)   ? (rx_phase && idx_reg == 3'h3) : 1'b0;
    assign ee_scl     = scl_reg;
    assign ee_sda_oe  = oe_reg;
    assign ee_sda_out = 1'b0;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg <= EAC_IDLE;
            q_reg     <= 2'h0;
            idx_reg   <= 3'h0;
            bit_reg   <= 3'h0;
            sh_reg    <= 8'h00;
            scl_reg   <= 1'b1;
            oe_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            q_reg     <= q_next;
            idx_reg   <= idx_next;
            bit_reg   <= bit_next;
            sh_reg    <= sh_next;
            scl_reg   <= scl_v;
            oe_reg    <= oe_v;
        end
    end

    // Received bits shift in; two bytes fill the word exactly
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_reg <= 16'h0000;
        end else if (state_reg == EAC_BITS && rx_phase && sample) begin
            rx_reg <= {rx_reg[14:0], ee_sda_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation bookkeeping and autoload sequencing
    assign al_end   = fin && !op_sw_reg &&
                      (fail_reg || al_addr_reg == AL_LAST || al_dis_reg);
    assign sw_rd_ok = fin && op_sw_reg && op_rd_reg && !fail_reg;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            op_rd_reg   <= 1'b1;
            op_sw_reg   <= 1'b0;
            op_addr_reg <= 7'h00;
            fail_reg    <= 1'b0;
            arm_reg     <= 1'b1;
            al_busy_reg <= 1'b0;
            al_done_reg <= 1'b0;
            al_addr_reg <= 7'h00;
        end else begin
            if (go) begin
                op_rd_reg   <= go_al || !cmd_reg; // [R3]
                op_sw_reg   <= go_sw;
                op_addr_reg <= go_al ? al_addr_reg : waddr_reg; // [R10]
            end
            fail_reg <= nack || (fail_reg && !go);
            arm_reg  <= 1'b0;
            if (arm_reg) begin
                al_busy_reg <= !al_dis_reg; // [R7]
            end else if (al_end) begin
                al_busy_reg <= 1'b0;
                al_done_reg <= !fail_reg; // [R5]
            end else if (fin && !op_sw_reg) begin
                al_addr_reg <= al_addr_reg + 7'h01;
            end
        end
    end

    // Loaded words leave on a one-cycle strobe
    assign ld_valid = ld_valid_reg;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ld_valid_reg <= 1'b0;
            ld_addr      <= 7'h00;
            ld_data      <= 16'h0000;
        end else begin
            ld_valid_reg <= fin && !op_sw_reg && !fail_reg;
            ld_addr      <= (fin && !op_sw_reg) ? op_addr_reg : ld_addr;
            ld_data      <= (fin && !op_sw_reg) ? rx_reg : ld_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control/status register; hardware updates win over software writes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            start_reg  <= 1'b0;
            cmd_reg    <= RST_CMD;
            err_reg    <= 1'b0;
            freq_reg   <= RST_FREQ;
            al_dis_reg <= RST_ALDIS;
            fast_reg   <= RST_FAST;
            waddr_reg  <= RST_WADDR;
            data_reg   <= RST_DATA;
        end else begin
            if (fin && op_sw_reg) begin
                start_reg <= 1'b0; // [R2]
            end else if (start_rise) begin
                start_reg <= 1'b1; // [R1]
            end
            err_reg <= nack || (err_reg && !go_sw && !arm_reg); // [R4]
            if (wr_ctrl && avs_byteenable[0]) begin
                cmd_reg    <= avs_writedata[B_CMD];
                freq_reg   <= avs_writedata[B_FREQ +: 2]; // [R6]
                al_dis_reg <= avs_writedata[B_ALDIS];
                fast_reg   <= avs_writedata[B_FAST];
            end
            if (wr_ctrl && avs_byteenable[1]) begin
                waddr_reg <= avs_writedata[B_WADDR +: 7];
            end
            if (sw_rd_ok) begin
                data_reg <= rx_reg; // [R12]
            end else if (wr_ctrl) begin
                data_reg[7:0]  <= avs_byteenable[2] ? avs_writedata[B_DATA +: 8] :
                                                      data_reg[7:0];
                data_reg[15:8] <= avs_byteenable[3] ? avs_writedata[B_DATA + 8 +: 8] :
                                                      data_reg[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts; a read of the status clears it, a new event still lands
    assign ev[IRQ_DONE] = fin && op_sw_reg;
    assign ev[IRQ_ERR]  = nack;
    assign ev[IRQ_AL]   = al_end;
    assign irq          = |(ist_reg & mask_reg);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ist_reg  <= 3'h0;
            mask_reg <= RST_MASK;
        end else begin
            ist_reg  <= (rd_stat ? 3'h0 : ist_reg) | ev;
            mask_reg <= wr_mask ? avs_writedata[2:0] : mask_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_start_launch: assert property (@(posedge clk_sys) disable iff (srst) // [R1]
        $rose(start_reg) |-> $past(start_rise) ##1 (go_sw || al_busy_reg || run))
        else $error("request bit rose without a software write or no launch");

    chk_start_clear: assert property (@(posedge clk_sys) disable iff (srst) // [R2]
        (fin && op_sw_reg) |=> !start_reg && (state_reg == EAC_IDLE))
        else $error("request bit not cleared when the cycle finished");

    chk_cmd_dir: assert property (@(posedge clk_sys) disable iff (srst) // [R3]
        go_sw |=> (op_rd_reg == !$past(cmd_reg)) && (state_reg == EAC_START))
        else $error("cycle direction does not follow the command bit");

    chk_ack_error: assert property (@(posedge clk_sys) disable iff (srst) // [R4]
        nack |=> err_reg && fail_reg ##1 (state_reg == EAC_ACK || state_reg == EAC_STOP))
        else $error("missing acknowledge not flagged");

    chk_al_done: assert property (@(posedge clk_sys) disable iff (srst) // [R5]
        $rose(al_done_reg) |-> $past(al_busy_reg) && !al_busy_reg && !$past(fail_reg))
        else $error("autoload complete set without a clean autoload");

    chk_al_skip: assert property (@(posedge clk_sys) disable iff (srst) // [R7]
        (fin && !op_sw_reg && al_dis_reg && al_busy_reg) |=> !al_busy_reg [*2])
        else $error("autoload ran on although disabled");

    chk_fast_rate: assert property (@(posedge clk_sys) disable iff (srst) // [R8]
        (al_busy_reg && fast_reg && freq_reg == 2'h3 && run && tick && !fin) |=> tick)
        else $error("fast autoload not at the raised rate");

    chk_busy_flag: assert property (@(posedge clk_sys) disable iff (srst) // [R9]
        (avs_read && hit_ctrl && !resp_reg) |=> avs_readdata[B_ALBUSY] == $past(al_busy_reg))
        else $error("in-progress bit does not show the autoload state");

    chk_addr_byte: assert property (@(posedge clk_sys) disable iff (srst) // [R10]
        (state_reg == EAC_ACK && step && idx_reg == 3'h0 && !fail_reg)
        |=> sh_reg == {1'b0, op_addr_reg})
        else $error("word address byte wrong");

    chk_write_data: assert property (@(posedge clk_sys) disable iff (srst) // [R11]
        (state_reg == EAC_ACK && step && idx_reg == 3'h1 && !op_rd_reg && !fail_reg)
        |=> sh_reg == data_reg[15:8])
        else $error("write data byte wrong");

    chk_read_return: assert property (@(posedge clk_sys) disable iff (srst) // [R12]
        sw_rd_ok |=> data_reg == $past(rx_reg))
        else $error("read word not returned to the data field");

endmodule // eac_ctrl

/* File: eac_pkg.sv */
// Constants shared by the EEPROM access control block
package eac_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h70;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h80;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h84;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions in the control/status word
    localparam int B_START   = 0;
    localparam int B_CMD     = 1;
    localparam int B_ERR     = 2;
    localparam int B_ALDONE  = 3;
    localparam int B_FREQ    = 4;
    localparam int B_ALDIS   = 6;
    localparam int B_FAST    = 7;
    localparam int B_ALBUSY  = 8;
    localparam int B_WADDR   = 9;
    localparam int B_DATA    = 16;

    // Interrupt status and mask bit positions
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ERR   = 1;
    localparam int IRQ_AL    = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic        RST_CMD   = 1'h0;
    localparam logic [1:0]  RST_FREQ  = 2'h0;
    localparam logic        RST_ALDIS = 1'h0;
    localparam logic        RST_FAST  = 1'h0;
    localparam logic [6:0]  RST_WADDR = 7'h00;
    localparam logic [15:0] RST_DATA  = 16'h0000;
    localparam logic [2:0]  RST_MASK  = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Clock division; each serial bit takes four quarter phases
    localparam int DIV_SEL0  = 4096;
    localparam int DIV_SEL1  = 2048;
    localparam int DIV_SEL2  = 1024;
    localparam int DIV_SEL3  = 128;
    localparam int FAST_MULT = 32;
    localparam logic [9:0] QTR_SEL0  = 10'(DIV_SEL0 / 4 - 1);
    localparam logic [9:0] QTR_SEL1  = 10'(DIV_SEL1 / 4 - 1);
    localparam logic [9:0] QTR_SEL2  = 10'(DIV_SEL2 / 4 - 1);
    localparam logic [9:0] QTR_SEL3  = 10'(DIV_SEL3 / 4 - 1);
    localparam logic [9:0] QTRF_SEL0 = 10'(DIV_SEL0 / (4 * FAST_MULT) - 1);
    localparam logic [9:0] QTRF_SEL1 = 10'(DIV_SEL1 / (4 * FAST_MULT) - 1);
    localparam logic [9:0] QTRF_SEL2 = 10'(DIV_SEL2 / (4 * FAST_MULT) - 1);
    localparam logic [9:0] QTRF_SEL3 = 10'(DIV_SEL3 / (4 * FAST_MULT) - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame constants (device select codes are arbitrary values)
    localparam logic [7:0] SEL_WR    = 8'hA0;
    localparam logic [7:0] SEL_RD    = 8'hA1;
    localparam logic [6:0] AL_LAST   = 7'h7F;

    typedef enum logic [2:0] {
        EAC_IDLE,
        EAC_START,
        EAC_BITS,
        EAC_ACK,
        EAC_STOP
    } eac_state_t;

endpackage

/* File: eac_clkdiv.sv */
// Quarter-phase strobe generator for the serial EEPROM clock
`timescale 1ns/1ps
module eac_clkdiv (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] sel,
    input  wire logic       fast,
    // Strobe, one cycle each quarter of the serial clock
    output logic            tick
);
    import eac_pkg::*;

    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    logic [9:0] lim_norm;
    logic [9:0] lim_fast;
    logic [9:0] limit;

    assign lim_norm = (sel == 2'h0) ? QTR_SEL0 : (sel == 2'h1) ? QTR_SEL1 :
                      (sel == 2'h2) ? QTR_SEL2 : QTR_SEL3;
    assign lim_fast = (sel == 2'h0) ? QTRF_SEL0 : (sel == 2'h1) ? QTRF_SEL1 :
                      (sel == 2'h2) ? QTRF_SEL2 : QTRF_SEL3;
    assign limit    = fast ? lim_fast : lim_norm; // [R8]
    assign tick     = run && (cnt_reg >= limit); // [R6]
    assign cnt_next = (!run || tick) ? 10'h000 : cnt_reg + 10'h001;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_reg <= 10'h000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [10:0] gap_reg;
    always_ff @(posedge clk_sys) begin
        if (srst || !run || tick) begin
            gap_reg <= 11'h000;
        end else begin
            gap_reg <= gap_reg + 11'h001;
        end
    end

    chk_tick_gap: assert property (@(posedge clk_sys) disable iff (srst) // [R6]
        (tick && $past(run) && $stable(sel) && $stable(fast) && !fast && $past(!tick))
        |-> (gap_reg == {1'b0, lim_norm}))
        else $error("quarter strobe spacing does not match the divider setting");

endmodule // eac_clkdiv

/* File: eac_eeprom_model.sv */
// Behavioural serial EEPROM answering the block's frames
`timescale 1ns/1ps
module eac_eeprom_model (
    // Serial pins; the data line already holds the pull-up level
    input  wire logic scl,
    input  wire logic sda,
    // Low leaves every byte unacknowledged
    input  wire logic ack_en,
    output logic      pull_low
);
    logic [15:0] mem [128];
    logic [15:0] tx;
    logic [7:0]  sh;
    logic [6:0]  ptr;
    logic        rd, rdsel, mack;
    int          cnt, byten;
    initial begin
        foreach (mem[i]) mem[i] = 16'(i * 16'h0B53 + 16'h1C2D);
        pull_low = 1'b0;
        rd = 1'b0;
        rdsel = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Start, restart and stop conditions
    always @(negedge sda) if (scl) begin
        cnt = 0;
        byten = 0;
        rd = 1'b0;
        rdsel = 1'b0;
    end
    always @(posedge sda) if (scl) rd = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Bits in on the rising clock, line changes only while the clock is low
    always @(posedge scl) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        if (cnt < 8 && rd) tx = tx << 1;
        if (cnt == 8) mack = !sda;
        cnt++;
    end
    always @(negedge scl) begin
        if (cnt == 8) begin
            pull_low = !rd && ack_en;
            if (!rd) case (byten)
                0: rdsel = sh[0];
                1: ptr = sh[6:0];
                2: tx[15:8] = sh;
                3: mem[ptr] = {tx[15:8], sh};
                default: ;
            endcase
        end else if (cnt == 9) begin
            cnt = 0;
            byten++;
            // A master that does not acknowledge ends the read
            if (rd && !mack) rd = 1'b0;
            if (rdsel && byten == 1) begin
                rd = 1'b1;
                tx = mem[ptr];
            end
        end
        if (cnt < 8) pull_low = rd && !tx[15];
    end
endmodule // eac_eeprom_model

/* File: eac_ctrl_test.sv */
// Self-checking bench for the EEPROM access control block
`timescale 1ns/1ps
module eac_ctrl_test;
    import eac_pkg::*;
    logic        clk_sys, srst, avs_read, avs_write, avs_waitrequest, irq;
    logic        ee_scl, ee_sda_out, ee_sda_oe, ld_valid, ack_en, scl_d;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable;
    logic [6:0]  ld_addr, a;
    logic [15:0] ld_data, d;
    wire logic   pull_low;
    wire logic   ee_sda_in = ~ee_sda_oe & ~pull_low;
    int          bad_count, check_count, cyc, per, last, loads, lb;
    eac_ctrl i_eac_ctrl (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .ee_scl(ee_scl),
        .ee_sda_in(ee_sda_in), .ee_sda_out(ee_sda_out), .ee_sda_oe(ee_sda_oe),
        .ld_valid(ld_valid), .ld_addr(ld_addr), .ld_data(ld_data));
    eac_eeprom_model i_eac_eeprom_model (.scl(ee_scl), .sda(ee_sda_in), .ack_en(ack_en),
        .pull_low(pull_low));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Request holds up to the edge that sees waitrequest low; read data taken there
    task automatic bus(logic wr, logic [7:0] ad, logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= ad;
        avs_writedata <= wd;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic ctl(logic [31:0] v);
        bus(1'b1, OFS_CTRL, v, q);
        do bus(1'b0, OFS_CTRL, 32'h0, q); while (q[B_START] !== 1'b0);
    endtask
    function automatic int div_of(int c);
        return (c == 3) ? 128 : (4096 >> c);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Serial clock period, autoload words and the run limit
    always @(posedge clk_sys) begin
        cyc++;
        if (ee_scl === 1'b1 && scl_d === 1'b0) begin
            per = cyc - last;
            last = cyc;
        end
        scl_d = ee_scl;
        if (ld_valid === 1'b1) begin
            loads++;
            check("ld_data", i_eac_eeprom_model.mem[ld_addr], ld_data);
        end
        if (cyc == 90000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(51));
        {srst, avs_read, avs_write, ack_en} = 4'h9;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        bus(1'b0, OFS_CTRL, 32'h0, q);
        check("ctrl reset", 32'h0000_0100, q);
        check("sda out", 32'h0, 32'(ee_sda_out));
        // Shortest divide plus fast mode keeps the full autoload short
        bus(1'b1, OFS_CTRL, 32'h0000_00B0, q);
        do bus(1'b0, OFS_CTRL, 32'h0, q); while (q[B_ALBUSY] !== 1'b0);
        check("autoload end", 32'h0000_00B8, q);
        check("autoload words", 32'd128, loads);
        check("autoload fast", 32'h1, 32'(cyc < 60000));
        check("irq masked", 32'h0, 32'(irq));
        bus(1'b1, OFS_IRQ_MASK, 32'h4, q);
        @(negedge clk_sys);
        check("irq raised", 32'h1, 32'(irq));
        bus(1'b0, OFS_IRQ_STAT, 32'h0, q);
        @(negedge clk_sys);
        check("irq status", 32'h4, q);
        check("irq cleared", 32'h0, 32'(irq));
        ack_en = 1'b0;
        for (int c = 3; c > 1; c--) begin
            ctl(32'(c << 4) | 32'h1);
            check("error flag", 32'h1, 32'(q[B_ERR]));
            check("scl period", div_of(c), per);
        end
        ack_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            a = 7'($urandom);
            d = 16'($urandom);
            ctl({d, a, 9'h033});
            check("written word", d, i_eac_eeprom_model.mem[a]);
            check("error clear", 32'h0, 32'(q[B_ERR]));
            a = 7'($urandom);
            ctl({~d, a, 9'h031});
            check("read word", i_eac_eeprom_model.mem[a], q[31:16]);
        end
        bus(1'b1, OFS_IRQ_MASK, 32'h1, q);
        @(negedge clk_sys);
        check("irq done", 32'h1, 32'(irq));
        bus(1'b0, OFS_IRQ_STAT, 32'h0, q);
        check("done status", 32'h1, 32'(q[IRQ_DONE]));
        bus(1'b1, 8'h74, 32'hFFFF_FFFF, q);
        bus(1'b0, 8'h74, 32'h0, q);
        check("unmapped", 32'h0, q);
        // Second reset while the link is idle; disabling stops autoload after one word
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        lb = loads;
        bus(1'b1, OFS_CTRL, 32'h0000_0070, q);
        do bus(1'b0, OFS_CTRL, 32'h0, q); while (q[B_ALBUSY] !== 1'b0);
        check("autoload stop", 32'h1, 32'(loads - lb));
        print_verdict();
    end
endmodule // eac_ctrl_test
